// *** ood_map.svh ***
`ifndef OOD_MAP_SVH
`define OOD_MAP_SVH

// Register offsets (byte addresses)
`define OOD_REG_CTRL 12'h000
`define OOD_REG_INSTR 12'h004
`define OOD_REG_DISP 12'h008
`define OOD_REG_BASE 12'h00C
`define OOD_REG_STATUS 12'h010
`define OOD_REG_EA 12'h014
`define OOD_REG_CYCLES 12'h018
`define OOD_REG_FLAGS 12'h01C

// Opcodes
`define OOD_OP_INTERRUPT_RETURN_OP 8'hCF
`define OOD_OP_RANGE 8'h62
`define OOD_OP_CARRY_CLR 8'hF8
`define OOD_OP_CARRY_INV 8'hF5
`define OOD_OP_CARRY_SET 8'hF9
`define OOD_OP_DIR_CLR 8'hFC
`define OOD_OP_DIR_SET 8'hFD
`define OOD_OP_IRQ_MASK 8'hFA
`define OOD_OP_IRQ_UNMASK 8'hFB
`define OOD_OP_LOCK 8'hF0

// Cycle costs
`define OOD_CYC_INTERRUPT_RETURN_OP 8'd28
`define OOD_CYC_RANGE_MIN 8'd33
`define OOD_CYC_RANGE_MAX 8'd35
`define OOD_CYC_FLAG 8'd2
`define OOD_CYC_WORD_XFER 8'd4
`define OOD_CYC_EA 8'd4

// Addressing byte fields
`define OOD_MOD_MSB 7
`define OOD_MOD_LSB 6
`define OOD_REG_MSB 5
`define OOD_REG_LSB 3
`define OOD_RM_MSB 2
`define OOD_RM_LSB 0
`define OOD_MOD_NONE 2'b00
`define OOD_MOD_D8 2'b01
`define OOD_MOD_D16 2'b10
`define OOD_MOD_REG 2'b11
`define OOD_RM_DIRECT 3'b110

// Status and control bits
`define OOD_ST_DONE 0
`define OOD_ST_SEG_PEND 1
`define OOD_ST_LOCK_PEND 2
`define OOD_ST_IS_REG 3
`define OOD_ST_UNKNOWN 4
`define OOD_CTRL_WORD 0
`define OOD_CTRL_XFERS_LSB 4

`endif

// *** ood_pkg.sv ***
package ood_pkg;
	typedef enum logic [1:0] {
		OOD_SEG_EXTRA = 2'b00,
		OOD_SEG_CODE = 2'b01,
		OOD_SEG_STACK = 2'b10,
		OOD_SEG_DATA = 2'b11
	} ood_seg_t;

	typedef enum logic [2:0] {
		OOD_ST_IDLE = 3'b000,
		OOD_ST_MODRM = 3'b001,
		OOD_ST_DLO = 3'b010,
		OOD_ST_DHI = 3'b011,
		OOD_ST_FINISH = 3'b100
	} ood_state_t;
endpackage : ood_pkg

// *** ood_ea_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// Inputs and results of effective-address formation
interface ood_ea_if;
	logic [1:0] mode;
	logic [2:0] rm;
	logic [15:0] disp;
	logic [15:0] base_x_word;
	logic [15:0] base_pointer_reg;
	logic [15:0] src_index_reg;
	logic [15:0] dest_index_reg;
	logic [15:0] effective_address;
	logic uses_bp;
	modport core (output mode, rm, disp, base_x_word, base_pointer_reg, src_index_reg,
		dest_index_reg, input effective_address, uses_bp);
	modport calc (input mode, rm, disp, base_x_word, base_pointer_reg, src_index_reg,
		dest_index_reg, output effective_address, uses_bp);
endinterface : ood_ea_if
`default_nettype wire

// *** ood_ea_calc.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ood_map.svh"
module ood_ea_calc
	import ood_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	ood_ea_if.calc ea
);
	logic [15:0] nxt_ea;
	logic nxt_bp;
	logic [15:0] ea_ff;

	// ========================================
	// Address combination
	always_comb begin
		nxt_bp = 1'b0;
		case (ea.rm)
			3'b000: nxt_ea = ea.base_x_word + ea.src_index_reg + ea.disp;
			3'b001: nxt_ea = ea.base_x_word + ea.dest_index_reg + ea.disp;
			3'b010: begin
				nxt_ea = ea.base_pointer_reg + ea.src_index_reg + ea.disp;
				nxt_bp = 1'b1;
			end
			3'b011: begin
				nxt_ea = ea.base_pointer_reg + ea.dest_index_reg + ea.disp;
				nxt_bp = 1'b1;
			end
			3'b100: nxt_ea = ea.src_index_reg + ea.disp;
			3'b101: nxt_ea = ea.dest_index_reg + ea.disp;
			3'b110: begin
				// Direct form carries no base register
				if (ea.mode == `OOD_MOD_NONE) begin
					nxt_ea = ea.disp;
				end else begin
					nxt_ea = ea.base_pointer_reg + ea.disp;
					nxt_bp = 1'b1;
				end
			end
			default: nxt_ea = ea.base_x_word + ea.disp;
		endcase
	end

	// Registered so the result lines up with the state machine
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ea_ff <= 16'h0000;
		end else begin
			ea_ff <= nxt_ea;
		end
	end
	assign ea.effective_address = ea_ff;
	// Unregistered: segment is picked in the cycle the address registers,
	// so a registered copy would still follow the previous addressing byte
	assign ea.uses_bp = nxt_bp && (ea.mode != `OOD_MOD_REG);
endmodule : ood_ea_calc
`default_nettype wire

// *** ood_decoder.sv ***
// What this block does
// - Byte CF is interrupt return, 28 cycles on both bus widths.
// - Byte 62 plus addressing byte is range check, 33 to 35 cycles.
// - Carry clear F8, invert F5, set F9; each 2 cycles.
// - FC clears, FD sets the string direction flag; 2 cycles each.
// - FA clears, FB sets the interrupt enable flag; 2 cycles each.
// - F0 is a lock prefix, 2 cycles, locking the next instruction.
// - Counts are for bytes; word range checks add 4 per memory transfer.
// - Mode 11 makes the r/m field a register selector.
// - Mode 00 gives zero displacement and fetches none, except direct.
// - Mode 01 fetches one byte, sign-extended to 16 bits.
// - Mode 10 fetches two bytes, low first, as 16-bit displacement.
// - r/m 000-011: base-x/base-pointer plus source/dest index plus displacement.
// - r/m 100-111: source, dest, base pointer, base-x plus displacement.
// - Mode 00 with r/m 110 is a direct 16-bit address.
// - Displacement bytes follow the addressing byte, before immediates.
// - Address formation costs 4 cycles, already inside the totals.
// - Prefix 001ss110 overrides segment: extra, code, stack, data.
// - Word registers 000-111: acc, count, data, base-x, sp, bp, si, di.
// - Operands addressed through base pointer default to stack segment.
// - String destinations always use extra segment; no override.
`timescale 1ns/1ps
`default_nettype none
`include "ood_map.svh"
module ood_decoder
	import ood_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// ========================================
	// Bus slave state
	logic aw_hold_ff, w_hold_ff, b_pend_ff, r_pend_ff;
	logic [11:0] awaddr_ff;
	logic [31:0] wdata_ff, rdata_ff;
	logic [1:0] bresp_ff, rresp_ff;
	logic wr_fire;
	logic [31:0] nxt_rdata;
	logic nxt_rerr;

	// ========================================
	// Software-written registers
	logic word_op_ff;
	logic [1:0] mem_xfers_ff;
	logic [15:0] base_x_ff, base_ptr_ff, src_idx_ff, dest_idx_ff;
	logic byte_push; // one instruction byte offered this cycle
	logic [7:0] byte_val;

	// ========================================
	// Decoder state
	ood_state_t state_ff;
	logic [7:0] opcode_ff, modrm_ff, dlo_ff;
	logic [15:0] disp_ff;
	logic [7:0] cycles_ff;
	logic [7:0] cycles_max_ff;
	logic done_ff, unknown_ff, is_reg_ff;
	logic seg_pend_ff, lock_pend_ff, lock_cur_ff;
	ood_seg_t seg_ovr_ff, seg_src_ff;
	logic carry_ff, dir_ff, irq_en_ff;
	logic [3:0] reg_sel_ff; // {byte_high, code} of selected register
	logic dest_string_ff;

	ood_ea_if ea_bus ();
	ood_ea_calc u_ea (
		.aclk(aclk),
		.aresetn(aresetn),
		.ea(ea_bus)
	);
	assign ea_bus.mode = modrm_ff[`OOD_MOD_MSB:`OOD_MOD_LSB];
	assign ea_bus.rm = modrm_ff[`OOD_RM_MSB:`OOD_RM_LSB];
	assign ea_bus.disp = disp_ff;
	assign ea_bus.base_x_word = base_x_ff;
	assign ea_bus.base_pointer_reg = base_ptr_ff;
	assign ea_bus.src_index_reg = src_idx_ff;
	assign ea_bus.dest_index_reg = dest_idx_ff;

	// ========================================
	// AXI write channels; address and data taken in either order
	assign wr_fire = aw_hold_ff && w_hold_ff && !b_pend_ff;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_ff <= 1'b0;
			w_hold_ff <= 1'b0;
			b_pend_ff <= 1'b0;
			awaddr_ff <= 12'h000;
			wdata_ff <= 32'h00000000;
			bresp_ff <= 2'b00;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_awready <= !aw_hold_ff && !s_axi_awready && s_axi_awvalid;
			s_axi_wready <= !w_hold_ff && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_ff <= 1'b1;
				awaddr_ff <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_ff <= 1'b1;
				wdata_ff <= s_axi_wdata;
			end
			if (wr_fire) begin
				aw_hold_ff <= 1'b0;
				w_hold_ff <= 1'b0;
				b_pend_ff <= 1'b1;
				bresp_ff <= (awaddr_ff > `OOD_REG_FLAGS || awaddr_ff[1:0] != 2'b00)
					? 2'b10 : 2'b00;
			end else if (b_pend_ff && s_axi_bready) begin
				b_pend_ff <= 1'b0;
			end
		end
	end
	assign s_axi_bvalid = b_pend_ff;
	assign s_axi_bresp = bresp_ff;

	// Byte strobes ignored: every register here is written as one whole word
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			word_op_ff <= 1'b0;
			mem_xfers_ff <= 2'b00;
			base_x_ff <= 16'h0000;
			base_ptr_ff <= 16'h0000;
			src_idx_ff <= 16'h0000;
			dest_idx_ff <= 16'h0000;
		end else if (wr_fire) begin
			if (awaddr_ff == `OOD_REG_CTRL) begin
				word_op_ff <= wdata_ff[`OOD_CTRL_WORD];
				mem_xfers_ff <= wdata_ff[`OOD_CTRL_XFERS_LSB+:2];
			end else if (awaddr_ff == `OOD_REG_BASE) begin
				base_x_ff <= wdata_ff[15:0];
				base_ptr_ff <= wdata_ff[31:16];
			end else if (awaddr_ff == `OOD_REG_DISP) begin
				src_idx_ff <= wdata_ff[15:0];
				dest_idx_ff <= wdata_ff[31:16];
			end
		end
	end
	// Instruction bytes arrive as writes to the queue port
	assign byte_push = wr_fire && awaddr_ff == `OOD_REG_INSTR;
	assign byte_val = wdata_ff[7:0];

	// ========================================
	// Decode sequencer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_ff <= OOD_ST_IDLE;
			opcode_ff <= 8'h00;
			modrm_ff <= 8'h00;
			dlo_ff <= 8'h00;
			disp_ff <= 16'h0000;
			done_ff <= 1'b0;
			unknown_ff <= 1'b0;
		end else begin
			case (state_ff)
				OOD_ST_IDLE: begin
					if (byte_push) begin
						opcode_ff <= byte_val;
						done_ff <= 1'b0;
						unknown_ff <= 1'b0;
						if (byte_val == `OOD_OP_RANGE) begin
							state_ff <= OOD_ST_MODRM;
						end else if (byte_val == `OOD_OP_LOCK ||
							(byte_val[7:5] == 3'b001 && byte_val[2:0] == 3'b110)) begin
							state_ff <= OOD_ST_IDLE; // prefix: wait for the instruction
						end else begin
							state_ff <= OOD_ST_FINISH;
						end
					end
				end
				OOD_ST_MODRM: begin
					if (byte_push) begin
						modrm_ff <= byte_val;
						disp_ff <= 16'h0000;
						// Displacement is fetched right after this byte
						if (byte_val[`OOD_MOD_MSB:`OOD_MOD_LSB] == `OOD_MOD_D8 ||
							byte_val[`OOD_MOD_MSB:`OOD_MOD_LSB] == `OOD_MOD_D16 ||
							(byte_val[`OOD_MOD_MSB:`OOD_MOD_LSB] == `OOD_MOD_NONE &&
							byte_val[`OOD_RM_MSB:`OOD_RM_LSB] == `OOD_RM_DIRECT)) begin
							state_ff <= OOD_ST_DLO;
						end else begin
							state_ff <= OOD_ST_FINISH;
						end
					end
				end
				OOD_ST_DLO: begin
					if (byte_push) begin
						dlo_ff <= byte_val;
						if (modrm_ff[`OOD_MOD_MSB:`OOD_MOD_LSB] == `OOD_MOD_D8) begin
							disp_ff <= {{8{byte_val[7]}}, byte_val};
							state_ff <= OOD_ST_FINISH;
						end else begin
							state_ff <= OOD_ST_DHI;
						end
					end
				end
				OOD_ST_DHI: begin
					if (byte_push) begin
						disp_ff <= {byte_val, dlo_ff};
						state_ff <= OOD_ST_FINISH;
					end
				end
				OOD_ST_FINISH: begin
					// One cycle lets the address unit register its result
					done_ff <= 1'b1;
					unknown_ff <= !(opcode_ff == `OOD_OP_INTERRUPT_RETURN_OP || opcode_ff == `OOD_OP_RANGE ||
						opcode_ff[7:4] == 4'hF);
					state_ff <= OOD_ST_IDLE;
				end
				default: state_ff <= OOD_ST_IDLE;
			endcase
		end
	end

	// ========================================
	// Prefix tracking, held only for the next instruction
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			seg_pend_ff <= 1'b0;
			lock_pend_ff <= 1'b0;
			lock_cur_ff <= 1'b0;
			seg_ovr_ff <= OOD_SEG_DATA;
		end else if (state_ff == OOD_ST_IDLE && byte_push) begin
			if (byte_val == `OOD_OP_LOCK) begin
				lock_pend_ff <= 1'b1;
			end else if (byte_val[7:5] == 3'b001 && byte_val[2:0] == 3'b110) begin
				seg_pend_ff <= 1'b1;
				seg_ovr_ff <= ood_seg_t'(byte_val[4:3]);
			end else begin
				lock_cur_ff <= lock_pend_ff;
			end
		end else if (state_ff == OOD_ST_FINISH) begin
			seg_pend_ff <= 1'b0;
			lock_pend_ff <= 1'b0;
		end
	end

	// ========================================
	// Flags and cycle cost of finished instruction
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			carry_ff <= 1'b0;
			dir_ff <= 1'b0;
			irq_en_ff <= 1'b0;
			cycles_ff <= 8'h00;
			cycles_max_ff <= 8'h00;
		end else if (state_ff == OOD_ST_IDLE && byte_push && byte_val == `OOD_OP_LOCK) begin
			cycles_ff <= `OOD_CYC_FLAG;
			cycles_max_ff <= `OOD_CYC_FLAG;
		end else if (state_ff == OOD_ST_FINISH) begin
			cycles_ff <= `OOD_CYC_FLAG;
			cycles_max_ff <= `OOD_CYC_FLAG;
			case (opcode_ff)
				`OOD_OP_CARRY_CLR: carry_ff <= 1'b0;
				`OOD_OP_CARRY_INV: carry_ff <= !carry_ff;
				`OOD_OP_CARRY_SET: carry_ff <= 1'b1;
				`OOD_OP_DIR_CLR: dir_ff <= 1'b0;
				`OOD_OP_DIR_SET: dir_ff <= 1'b1;
				`OOD_OP_IRQ_MASK: irq_en_ff <= 1'b0;
				`OOD_OP_IRQ_UNMASK: irq_en_ff <= 1'b1;
				`OOD_OP_INTERRUPT_RETURN_OP: begin
					cycles_ff <= `OOD_CYC_INTERRUPT_RETURN_OP;
					cycles_max_ff <= `OOD_CYC_INTERRUPT_RETURN_OP;
				end
				`OOD_OP_RANGE: begin
					// Address cost already folded into these totals
					cycles_ff <= `OOD_CYC_RANGE_MIN +
						(word_op_ff ? 8'(`OOD_CYC_WORD_XFER * mem_xfers_ff) : 8'h00);
					cycles_max_ff <= `OOD_CYC_RANGE_MAX +
						(word_op_ff ? 8'(`OOD_CYC_WORD_XFER * mem_xfers_ff) : 8'h00);
				end
				default: begin
					cycles_ff <= 8'h00;
					cycles_max_ff <= 8'h00;
				end
			endcase
		end
	end

	// ========================================
	// Register operand and segment selection
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			is_reg_ff <= 1'b0;
			reg_sel_ff <= 4'h0;
			seg_src_ff <= OOD_SEG_DATA;
			dest_string_ff <= 1'b0;
		end else if (state_ff == OOD_ST_FINISH) begin
			is_reg_ff <= modrm_ff[`OOD_MOD_MSB:`OOD_MOD_LSB] == `OOD_MOD_REG;
			if (word_op_ff) begin
				reg_sel_ff <= {1'b0, modrm_ff[`OOD_RM_MSB:`OOD_RM_LSB]};
			end else begin
				reg_sel_ff <= {modrm_ff[2], 1'b0, modrm_ff[1:0]};
			end
			// Override wins over the default, base pointer defaults to stack
			if (seg_pend_ff) begin
				seg_src_ff <= seg_ovr_ff;
			end else if (ea_bus.uses_bp) begin
				seg_src_ff <= OOD_SEG_STACK;
			end else begin
				seg_src_ff <= OOD_SEG_DATA;
			end
			dest_string_ff <= 1'b1;
		end
	end

	// ========================================
	// Read decode
	always_comb begin
		nxt_rerr = 1'b0;
		if (s_axi_araddr == `OOD_REG_CTRL) begin
			nxt_rdata = {26'h0, mem_xfers_ff, 3'h0, word_op_ff};
		end else if (s_axi_araddr == `OOD_REG_INSTR) begin
			nxt_rdata = {8'h00, dlo_ff, modrm_ff, opcode_ff};
		end else if (s_axi_araddr == `OOD_REG_DISP) begin
			nxt_rdata = {dest_idx_ff, src_idx_ff};
		end else if (s_axi_araddr == `OOD_REG_BASE) begin
			nxt_rdata = {base_ptr_ff, base_x_ff};
		end else if (s_axi_araddr == `OOD_REG_STATUS) begin
			nxt_rdata = {27'h0, unknown_ff, is_reg_ff, lock_pend_ff, seg_pend_ff, done_ff};
		end else if (s_axi_araddr == `OOD_REG_EA) begin
			nxt_rdata = {disp_ff, ea_bus.effective_address};
		end else if (s_axi_araddr == `OOD_REG_CYCLES) begin
			nxt_rdata = {16'h0, cycles_max_ff, cycles_ff};
		end else if (s_axi_araddr == `OOD_REG_FLAGS) begin
			// Extra segment is fixed for string destinations
			nxt_rdata = {16'h0, 2'(OOD_SEG_EXTRA), dest_string_ff, lock_cur_ff, reg_sel_ff,
				2'(seg_src_ff), 3'h0, irq_en_ff, dir_ff, carry_ff};
		end else begin
			nxt_rdata = 32'h00000000;
			nxt_rerr = 1'b1;
		end
	end

	// One read at a time; answer one cycle after acceptance
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r_pend_ff <= 1'b0;
			rdata_ff <= 32'h00000000;
			rresp_ff <= 2'b00;
			s_axi_arready <= 1'b0;
		end else begin
			s_axi_arready <= !r_pend_ff && !s_axi_arready && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				r_pend_ff <= 1'b1;
				rdata_ff <= nxt_rdata;
				rresp_ff <= nxt_rerr ? 2'b10 : 2'b00;
			end else if (r_pend_ff && s_axi_rready) begin
				r_pend_ff <= 1'b0;
			end
		end
	end
	assign s_axi_rvalid = r_pend_ff;
	assign s_axi_rdata = rdata_ff;
	assign s_axi_rresp = rresp_ff;

	// ========================================
	// Checks
	property p_interrupt_return_op_cost;
		@(posedge aclk) disable iff (!aresetn)
		(state_ff == OOD_ST_FINISH && opcode_ff == `OOD_OP_INTERRUPT_RETURN_OP) |=> cycles_ff == 8'd28;
	endproperty
	a_interrupt_return_op_cost: assert property (p_interrupt_return_op_cost) else $error("return cost wrong");

	property p_d8_sign;
		@(posedge aclk) disable iff (!aresetn)
		(state_ff == OOD_ST_DLO && byte_push && modrm_ff[7:6] == 2'b01)
			|=> disp_ff == {{8{$past(byte_val[7])}}, $past(byte_val)};
	endproperty
	a_d8_sign: assert property (p_d8_sign) else $error("displacement not extended");

	property p_carry_set;
		@(posedge aclk) disable iff (!aresetn)
		(state_ff == OOD_ST_FINISH && opcode_ff == `OOD_OP_CARRY_SET) |=> carry_ff ##1 carry_ff;
	endproperty
	a_carry_set: assert property (p_carry_set) else $error("carry not set");

	property p_prefix_clear;
		@(posedge aclk) disable iff (!aresetn)
		state_ff == OOD_ST_FINISH |=> !seg_pend_ff && !lock_pend_ff;
	endproperty
	a_prefix_clear: assert property (p_prefix_clear) else $error("prefix kept");

	property p_range_cost;
		@(posedge aclk) disable iff (!aresetn)
		(state_ff == OOD_ST_FINISH && opcode_ff == `OOD_OP_RANGE && !word_op_ff)
			|=> cycles_ff == `OOD_CYC_RANGE_MIN && cycles_max_ff == `OOD_CYC_RANGE_MAX;
	endproperty
	a_range_cost: assert property (p_range_cost) else $error("range check cost wrong");

	property p_bp_stack;
		@(posedge aclk) disable iff (!aresetn)
		(state_ff == OOD_ST_FINISH && !seg_pend_ff && ea_bus.uses_bp)
			|=> seg_src_ff == OOD_SEG_STACK;
	endproperty
	a_bp_stack: assert property (p_bp_stack) else $error("base pointer not on stack");

	property p_reg_mode;
		@(posedge aclk) disable iff (!aresetn)
		(state_ff == OOD_ST_FINISH && modrm_ff[7:6] == `OOD_MOD_REG) |=> is_reg_ff;
	endproperty
	a_reg_mode: assert property (p_reg_mode) else $error("register mode missed");
endmodule : ood_decoder
`default_nettype wire

// *** ood_prefetch_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Register-bus stand-in for the prefetch queue and execution unit
module ood_prefetch_model
	import ood_pkg::*;
(
	input wire logic aclk,
	output logic [11:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic wready,
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output logic bready,
	output logic [11:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output logic rready
);
	// Bus idle from time zero, nothing offered before reset ends
	initial begin
		awaddr = 12'h000;
		awvalid = 1'b0;
		wdata = 32'h0000_0000;
		wstrb = 4'hF;
		wvalid = 1'b0;
		bready = 1'b0;
		araddr = 12'h000;
		arvalid = 1'b0;
		rready = 1'b0;
	end

	// One write; address and data may be taken on different edges
	task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		logic fin;
		fin = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!fin) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid === 1'b1) begin
				fin = 1'b1;
				r = bresp;
				bready <= 1'b0;
			end
		end
	endtask : wr

	// One read; rready held until the answer is sampled
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		logic fin;
		fin = 1'b0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!fin) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid === 1'b1) begin
				fin = 1'b1;
				d = rdata;
				r = rresp;
				rready <= 1'b0;
			end
		end
	endtask : rd
endmodule : ood_prefetch_model
`default_nettype wire

// *** ood_decoder_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ood_map.svh"
// ==========================================================
// Self-checking bench for the opcode and operand decoder
module ood_decoder_tb_top
	import ood_pkg::*;
;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	int miscompares = 0;
	int comparisons = 0;
	// Table rows: opcode, flags {irq,dir,carry} after it, minimum cost
	localparam logic [7:0] ROW_OP [9] = '{8'hF9, 8'hF5, 8'hF5, 8'hF8, 8'hFD, 8'hFC, 8'hFB,
		8'hFA, 8'hCF};
	localparam logic [31:0] ROW_FL [9] = '{32'h1, 32'h0, 32'h1, 32'h0, 32'h2, 32'h0, 32'h4,
		32'h0, 32'h0};
	localparam logic [31:0] ROW_CY [9] = '{32'h2, 32'h2, 32'h2, 32'h2, 32'h2, 32'h2, 32'h2,
		32'h2, 32'h1C};

	// ==========================================================
	// Clock, design and bus partner
	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end

	ood_decoder i_ood_decoder (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready));

	ood_prefetch_model i_ood_prefetch_model (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready));

	// ==========================================================
	// Compare and bus helpers
	task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_data

	task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_resp

	task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
		logic [1:0] r;
		i_ood_prefetch_model.wr(a, d, r);
		chk_resp(r, 2'b00);
	endtask : wr_reg

	// Masked read so undocumented bits of a word never decide a compare
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		i_ood_prefetch_model.rd(a, d, r);
		chk_resp(r, 2'b00);
		chk_data(d & m, e);
	endtask : rd_chk

	// Poll a status bit; only the watchdog ends a wait that never finishes
	task automatic wait_bit(input int idx);
		logic [31:0] d;
		logic [1:0] r;
		d = 32'h0000_0000;
		while (d[idx] !== 1'b1) i_ood_prefetch_model.rd(`OOD_REG_STATUS, d, r);
	endtask : wait_bit

	// Bytes go out in stream order: opcode, addressing byte, displacement low, high
	task automatic instr(input logic [7:0] b [4], input int n);
		for (int i = 0; i < n; i++) wr_reg(`OOD_REG_INSTR, {24'h000000, b[i]});
		wait_bit(`OOD_ST_DONE);
	endtask : instr

	task automatic do_reset();
		aresetn <= 1'b0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
	endtask : do_reset

	task automatic final_report();
		if (miscompares == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : final_report

	// ==========================================================
	// Main sequence
	initial begin
		logic [1:0] r;
		logic [31:0] d;
		aresetn = 1'b0;
		do_reset();
		wr_reg(`OOD_REG_DISP, 32'h2000_1000);
		wr_reg(`OOD_REG_BASE, 32'h4000_3000);
		// Flag and control opcodes from the table
		for (int i = 0; i < 9; i++) begin
			instr('{ROW_OP[i], 8'h00, 8'h00, 8'h00}, 1);
			rd_chk(`OOD_REG_CYCLES, 32'h0000_00FF, ROW_CY[i]);
			if (ROW_OP[i] != 8'hCF) rd_chk(`OOD_REG_FLAGS, 32'h7, ROW_FL[i]);
		end
		// Range check, every displacement form
		instr('{8'h62, 8'h44, 8'h80, 8'h00}, 3);
		rd_chk(`OOD_REG_EA, 32'hFFFF_FFFF, 32'hFF80_0F80);
		rd_chk(`OOD_REG_CYCLES, 32'h0000_FFFF, 32'h2321);
		instr('{8'h62, 8'h82, 8'h34, 8'h12}, 4);
		rd_chk(`OOD_REG_EA, 32'hFFFF_FFFF, 32'h1234_6234);
		rd_chk(`OOD_REG_FLAGS, 32'h00C0, 32'h0080);
		instr('{8'h62, 8'h06, 8'h78, 8'h56}, 4);
		rd_chk(`OOD_REG_EA, 32'hFFFF_FFFF, 32'h5678_5678);
		instr('{8'h62, 8'h01, 8'h00, 8'h00}, 2);
		rd_chk(`OOD_REG_EA, 32'hFFFF_FFFF, 32'h0000_5000);
		instr('{8'h62, 8'hC3, 8'h00, 8'h00}, 2);
		rd_chk(`OOD_REG_STATUS, 32'h8, 32'h8);
		rd_chk(`OOD_REG_FLAGS, 32'h0F00, 32'h0300);
		// Word operation with one memory transfer adds four cycles
		wr_reg(`OOD_REG_CTRL, 32'h0000_0011);
		instr('{8'h62, 8'h07, 8'h00, 8'h00}, 2);
		rd_chk(`OOD_REG_CYCLES, 32'h0000_FFFF, 32'h2725);
		rd_chk(`OOD_REG_FLAGS, 32'h0F00, 32'h0700);
		wr_reg(`OOD_REG_CTRL, 32'h0000_0000);
		// Every override code, each for one instruction only
		for (int s = 0; s < 4; s++) begin
			wr_reg(`OOD_REG_INSTR, {24'h000000, 3'b001, s[1:0], 3'b110});
			wait_bit(`OOD_ST_SEG_PEND);
			instr('{8'h62, 8'h07, 8'h00, 8'h00}, 2);
			rd_chk(`OOD_REG_FLAGS, 32'h00C0, {24'h0, s[1:0], 6'h00});
			rd_chk(`OOD_REG_FLAGS, 32'hE000, 32'h2000);
			rd_chk(`OOD_REG_EA, 32'h0000_FFFF, 32'h0000_3000);
		end
		instr('{8'h62, 8'h07, 8'h00, 8'h00}, 2);
		rd_chk(`OOD_REG_FLAGS, 32'h00C0, 32'h00C0);
		// Lock prefix stays for the next instruction only
		wr_reg(`OOD_REG_INSTR, 32'h0000_00F0);
		wait_bit(`OOD_ST_LOCK_PEND);
		rd_chk(`OOD_REG_CYCLES, 32'h0000_FFFF, 32'h0202);
		instr('{8'hF8, 8'h00, 8'h00, 8'h00}, 1);
		rd_chk(`OOD_REG_STATUS, 32'h6, 32'h0);
		rd_chk(`OOD_REG_FLAGS, 32'h1000, 32'h1000);
		// Unmapped place refused on both channels
		i_ood_prefetch_model.wr(12'h020, 32'h0000_00FF, r);
		chk_resp(r, 2'b10);
		i_ood_prefetch_model.rd(12'h020, d, r);
		chk_resp(r, 2'b10);
		chk_data(d, 32'h0000_0000);
		// Reset in mid-run drops a pending override
		wr_reg(`OOD_REG_INSTR, 32'h0000_002E);
		wait_bit(`OOD_ST_SEG_PEND);
		do_reset();
		rd_chk(`OOD_REG_STATUS, 32'h6, 32'h0);
		final_report();
	end

	// Watchdog well beyond the few hundred cycles the run needs
	initial begin
		repeat (50000) @(posedge aclk);
		miscompares++;
		final_report();
	end
endmodule : ood_decoder_tb_top
`default_nettype wire
